// File: verilog/nbp_host_regs.vh
`ifndef NBP_HOST_REGS_VH
`define NBP_HOST_REGS_VH

// apb register offsets, one aligned word each
`define NBP_OFS_CTRL        12'h000
`define NBP_OFS_ADDR        12'h004
`define NBP_OFS_PERM        12'h008
`define NBP_OFS_PINS        12'h00c
`define NBP_OFS_STATUS      12'h010
`define NBP_OFS_GROUPS      12'h014

// address register fields
`define NBP_ADDR_LOWER      10:0
`define NBP_ADDR_UPPER      26:16
`define NBP_ADDR_INVERT     31

// permanent register fields
`define NBP_PERM_GROUP      3:0
`define NBP_PERM_FREEZE     4

// pin register fields and reset values
`define NBP_PINS_WP_N       0
`define NBP_PINS_VPE        1
`define NBP_RST_WP_N        1'b0
`define NBP_RST_VPE         1'b0

// status register fields
`define NBP_ST_BUSY         0
`define NBP_ST_DONE         1
`define NBP_ST_REFUSED      2
`define NBP_ST_RB           3
`define NBP_ST_PROT         15:8
`define NBP_ST_NAND         23:16
`define NBP_ST_ATTEMPTS     28:24

// operation codes written to the control register
`define NBP_OP_RESET        3'h0
`define NBP_OP_UNLOCK       3'h1
`define NBP_OP_LOCK_ALL     3'h2
`define NBP_OP_LOCK_DOWN    3'h3
`define NBP_OP_PERMANENT    3'h4
`define NBP_OP_STATUS       3'h5

// device command bytes
`define NBP_CMD_UNLOCK_LO   8'h23
`define NBP_CMD_UNLOCK_HI   8'h24
`define NBP_CMD_LOCK_ALL    8'h2a
`define NBP_CMD_LOCK_DOWN   8'h2c
`define NBP_CMD_ENTRY1      8'h4c
`define NBP_CMD_ENTRY2      8'h03
`define NBP_CMD_ENTRY3      8'h1d
`define NBP_CMD_ENTRY4      8'h41
`define NBP_CMD_PROG        8'h80
`define NBP_CMD_CONFIRM     8'h10
`define NBP_CMD_RD_STATUS   8'h70
`define NBP_CMD_PROT_READ   8'h7a
`define NBP_CMD_RESET       8'hff

// bus cycle kinds
`define NBP_K_CMD           2'h0
`define NBP_K_ADDR          2'h1
`define NBP_K_READ          2'h2
`define NBP_K_WAIT          2'h3

// permanent attempt ceiling
`define NBP_MAX_ATTEMPTS    5'h10

// timing in ns and derived cycle counts (least times round up)
`define NBP_CLK_NS          25
`define NBP_TWP_NS          25
`define NBP_TRP_NS          50
`define NBP_TWHR_NS         60
`define NBP_TWB_NS          100
`define NBP_CYC(ns)         (((ns) + `NBP_CLK_NS - 1) / `NBP_CLK_NS)

`endif

// File: verilog/nbp_cycle.v
`timescale 1ns/10ps
`include "nbp_host_regs.vh"

// one byte-bus cycle: command, address, data read or wait for ready
module nbp_cycle (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_start,
    input  wire [1:0] i_kind,
    input  wire [7:0] i_byte,
    input  wire [7:0] i_nand_io,
    input  wire       i_ready_busy_line,
    output reg        o_done,
    output reg  [7:0] o_rdata,
    output reg        o_nand_cle,
    output reg        o_nand_ale,
    output reg        o_nand_we_n,
    output reg        o_nand_re_n,
    output reg  [7:0] o_nand_io,
    output reg        o_nand_io_oe
);
    localparam [2:0] C_IDLE  = 3'h0;
    localparam [2:0] C_SETUP = 3'h1;
    localparam [2:0] C_PULSE = 3'h2;
    localparam [2:0] C_HOLD  = 3'h3;
    localparam [2:0] C_WB    = 3'h4;
    localparam [2:0] C_BUSY  = 3'h5;

    // cycle counts worked out at full width, then cut to the counter width
    localparam integer W_WP  = `NBP_CYC(`NBP_TWP_NS);
    localparam integer W_RP  = `NBP_CYC(`NBP_TRP_NS);
    localparam integer W_WHR = `NBP_CYC(`NBP_TWHR_NS);
    localparam integer W_WB  = `NBP_CYC(`NBP_TWB_NS);
    localparam [3:0]   N_WP  = W_WP[3:0];
    localparam [3:0]   N_RP  = W_RP[3:0];
    localparam [3:0]   N_WHR = W_WHR[3:0];
    localparam [3:0]   N_WB  = W_WB[3:0];

    reg [2:0] state;
    reg [1:0] kind;
    reg [3:0] cnt;

    // phase sequencer, all pins from flops
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_srst) begin
            state        <= C_IDLE;
            kind         <= `NBP_K_CMD;
            cnt          <= 4'h0;
            o_rdata      <= 8'h00;
            o_nand_cle   <= 1'b0;
            o_nand_ale   <= 1'b0;
            o_nand_we_n  <= 1'b1;
            o_nand_re_n  <= 1'b1;
            o_nand_io    <= 8'h00;
            o_nand_io_oe <= 1'b0;
        end else begin
            case (state)
                C_IDLE: begin
                    if (i_start) begin
                        kind <= i_kind;
                        if (i_kind == `NBP_K_WAIT) begin
                            cnt   <= N_WB;
                            state <= C_WB;
                        end else begin
                            o_nand_cle   <= (i_kind == `NBP_K_CMD);
                            o_nand_ale   <= (i_kind == `NBP_K_ADDR);
                            o_nand_io    <= i_byte;
                            o_nand_io_oe <= (i_kind != `NBP_K_READ);
                            state        <= C_SETUP;
                        end
                    end
                end
                C_SETUP: begin
                    if (kind == `NBP_K_READ) begin
                        o_nand_re_n <= 1'b0;
                        cnt         <= N_RP;
                    end else begin
                        o_nand_we_n <= 1'b0;
                        cnt         <= N_WP;
                    end
                    state <= C_PULSE;
                end
                C_PULSE: begin
                    if (cnt <= 4'h1) begin
                        if (kind == `NBP_K_READ)
                            o_rdata <= i_nand_io; // sampled before re rises
                        o_nand_we_n <= 1'b1;
                        o_nand_re_n <= 1'b1;
                        cnt         <= N_WHR;
                        state       <= C_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                C_HOLD: begin
                    // hold latch lines, then gap before next cycle
                    o_nand_cle   <= 1'b0;
                    o_nand_ale   <= 1'b0;
                    o_nand_io_oe <= 1'b0;
                    if (cnt <= 4'h1) begin
                        o_done <= 1'b1;
                        state  <= C_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                C_WB: begin
                    // let the busy line fall before watching it
                    if (cnt <= 4'h1)
                        state <= C_BUSY;
                    else
                        cnt <= cnt - 4'h1;
                end
                C_BUSY: begin
                    if (i_ready_busy_line) begin
                        o_done <= 1'b1;
                        state  <= C_IDLE;
                    end
                end
                default: state <= C_IDLE;
            endcase
        end
    end
endmodule // nbp_cycle

// File: verilog/nbp_host.v
`timescale 1ns/10ps
`include "nbp_host_regs.vh"

// Behaviour
// - unlock range sends 23h then 24h
// - unlock address in three placed cycles
// - write-protect and enable high before lock-down
// - end permanent sequences with FFh
// - no reset while permanent program busy
// - at most sixteen permanent attempts, no repeats
// - status read 7Ah, three addresses, one byte
// - status address like unlock, bit zero low
// - enable pin high for volatile commands
module nbp_host (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    input  wire [7:0]  i_nand_io,
    input  wire        i_ready_busy_line,
    output wire [7:0]  o_nand_io,
    output wire        o_nand_io_oe,
    output wire        o_nand_cle,
    output wire        o_nand_ale,
    output reg         o_nand_ce_n,
    output wire        o_nand_we_n,
    output wire        o_nand_re_n,
    output reg         o_write_protect_n,
    output reg         o_volatile_protect_enable_pin
);
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_ISSUE = 2'h1;
    localparam [1:0] S_WAIT  = 2'h2;

    reg  [1:0]  state;
    reg  [2:0]  op;
    reg  [4:0]  idx;
    reg  [31:0] addr_reg;
    reg  [4:0]  perm_reg;
    reg         done;
    reg         refused;
    reg  [7:0]  block_protection_status;
    reg  [7:0]  nand_status;
    reg  [4:0]  attempts;
    reg  [15:0] groups_tried;
    reg         cyc_start;
    reg         refuse_now;
    wire [10:0] step;
    wire        cyc_done;
    wire [7:0]  cyc_rdata;
    wire        wr_access;
    wire        rd_setup;
    wire        mapped;
    wire        ctrl_wr;

    // one address cycle of a block address; first cycle carries bit0
    function [7:0] nbp_ba_cycle;
        input [10:0] ba;
        input [1:0]  n;
        input        bit0;
        begin
            case (n)
                2'h0:    nbp_ba_cycle = {ba[1:0], 5'h00, bit0};
                2'h1:    nbp_ba_cycle = ba[9:2];
                default: nbp_ba_cycle = {7'h00, ba[10]};
            endcase
        end
    endfunction

    // step table: {last, kind, byte} for operation o at index i
    function [10:0] nbp_step;
        input [2:0]  o;
        input [4:0]  i;
        input [31:0] ar;
        input [4:0]  pg;
        reg   [10:0] lb;
        reg   [10:0] ub;
        begin
            lb       = ar[`NBP_ADDR_LOWER];
            ub       = ar[`NBP_ADDR_UPPER];
            nbp_step = {1'b1, `NBP_K_CMD, `NBP_CMD_RESET};
            case (o)
                `NBP_OP_UNLOCK: begin
                    case (i)
                        5'h0: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_UNLOCK_LO};
                        // invert position sent low with 23h
                        5'h1: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h0, 1'b0)};
                        5'h2: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h1, 1'b0)};
                        5'h3: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h2, 1'b0)};
                        5'h4: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_UNLOCK_HI};
                        // invert bit rides on upper boundary
                        5'h5: nbp_step = {1'b0, `NBP_K_ADDR,
                                          nbp_ba_cycle(ub, 2'h0, ar[`NBP_ADDR_INVERT])};
                        5'h6: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(ub, 2'h1, 1'b0)};
                        default: nbp_step = {1'b1, `NBP_K_ADDR, nbp_ba_cycle(ub, 2'h2, 1'b0)};
                    endcase
                end
                `NBP_OP_LOCK_ALL:  nbp_step = {1'b1, `NBP_K_CMD, `NBP_CMD_LOCK_ALL};
                `NBP_OP_LOCK_DOWN: nbp_step = {1'b1, `NBP_K_CMD, `NBP_CMD_LOCK_DOWN};
                `NBP_OP_STATUS: begin
                    case (i)
                        5'h0: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_PROT_READ};
                        // same placement, bit zero held low
                        5'h1: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h0, 1'b0)};
                        5'h2: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h1, 1'b0)};
                        5'h3: nbp_step = {1'b0, `NBP_K_ADDR, nbp_ba_cycle(lb, 2'h2, 1'b0)};
                        default: nbp_step = {1'b1, `NBP_K_READ, 8'h00};
                    endcase
                end
                `NBP_OP_PERMANENT: begin
                    case (i)
                        5'h0: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_ENTRY1};
                        5'h1: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_ENTRY2};
                        5'h2: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_ENTRY3};
                        5'h3: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_ENTRY4};
                        5'h4: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_PROG};
                        5'h5: nbp_step = {1'b0, `NBP_K_ADDR, 8'h00};
                        5'h6: nbp_step = {1'b0, `NBP_K_ADDR, 8'h00};
                        5'h7: nbp_step = {1'b0, `NBP_K_ADDR, 8'h00};
                        // group in low nibble; freeze in upper nibble
                        5'h8: nbp_step = {1'b0, `NBP_K_ADDR, 3'h0, pg};
                        5'h9: nbp_step = {1'b0, `NBP_K_ADDR, 8'h00};
                        5'ha: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_CONFIRM};
                        // wait for ready before anything else
                        5'hb: nbp_step = {1'b0, `NBP_K_WAIT, 8'h00};
                        5'hc: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_RD_STATUS};
                        5'hd: nbp_step = {1'b0, `NBP_K_READ, 8'h00};
                        5'he: nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_RESET};
                        default: nbp_step = {1'b1, `NBP_K_WAIT, 8'h00};
                    endcase
                end
                default: begin
                    if (i == 5'h0)
                        nbp_step = {1'b0, `NBP_K_CMD, `NBP_CMD_RESET};
                    else
                        nbp_step = {1'b1, `NBP_K_WAIT, 8'h00};
                end
            endcase
        end
    endfunction

    assign step      = nbp_step(op, idx, addr_reg, perm_reg);
    assign wr_access = i_psel & i_penable & i_pwrite;
    assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
    assign mapped    = (i_paddr == `NBP_OFS_CTRL) | (i_paddr == `NBP_OFS_ADDR) |
                       (i_paddr == `NBP_OFS_PERM) | (i_paddr == `NBP_OFS_PINS) |
                       (i_paddr == `NBP_OFS_STATUS) | (i_paddr == `NBP_OFS_GROUPS);
    assign ctrl_wr   = wr_access & (i_paddr == `NBP_OFS_CTRL);
    // zero wait states; unmapped offsets answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // refusal check for a newly written operation
    always @* begin
        refuse_now = (state != S_IDLE);
        case (i_pwdata[2:0])
            `NBP_OP_UNLOCK,
            `NBP_OP_LOCK_ALL:
                // volatile commands need the enable pin high
                refuse_now = refuse_now | ~o_volatile_protect_enable_pin;
            `NBP_OP_LOCK_DOWN:
                refuse_now = refuse_now | ~o_volatile_protect_enable_pin |
                             ~o_write_protect_n;
            `NBP_OP_PERMANENT:
                // attempt ceiling and no repeat of a group
                refuse_now = refuse_now | (attempts >= `NBP_MAX_ATTEMPTS) |
                             groups_tried[perm_reg[`NBP_PERM_GROUP]];
            `NBP_OP_RESET,
            `NBP_OP_STATUS:
                refuse_now = refuse_now;
            default:
                refuse_now = 1'b1;
        endcase
    end

    // software registers and pin levels
    always @(posedge i_clk) begin
        if (i_srst) begin
            addr_reg                      <= 32'h0000_0000;
            perm_reg                      <= 5'h00;
            o_write_protect_n             <= `NBP_RST_WP_N;
            o_volatile_protect_enable_pin <= `NBP_RST_VPE;
        end else if (wr_access) begin
            if (i_paddr == `NBP_OFS_ADDR)
                addr_reg <= i_pwdata & 32'h87ff_07ff;
            if (i_paddr == `NBP_OFS_PERM && state == S_IDLE)
                perm_reg <= i_pwdata[4:0];
            if (i_paddr == `NBP_OFS_PINS) begin
                o_write_protect_n             <= i_pwdata[`NBP_PINS_WP_N];
                o_volatile_protect_enable_pin <= i_pwdata[`NBP_PINS_VPE];
            end
        end
    end

    // read data, registered in the setup phase
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (i_paddr)
                `NBP_OFS_CTRL:   o_prdata <= {29'h0, op};
                `NBP_OFS_ADDR:   o_prdata <= addr_reg;
                `NBP_OFS_PERM:   o_prdata <= {27'h0, perm_reg};
                `NBP_OFS_PINS:   o_prdata <= {30'h0, o_volatile_protect_enable_pin,
                                              o_write_protect_n};
                `NBP_OFS_STATUS: o_prdata <= {3'h0, attempts, nand_status,
                                              block_protection_status, 4'h0,
                                              i_ready_busy_line, refused, done,
                                              state != S_IDLE};
                `NBP_OFS_GROUPS: o_prdata <= {16'h0, groups_tried};
                default:         o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // operation sequencer
    always @(posedge i_clk) begin
        cyc_start <= 1'b0;
        if (i_srst) begin
            state                   <= S_IDLE;
            op                      <= `NBP_OP_RESET;
            idx                     <= 5'h00;
            done                    <= 1'b0;
            refused                 <= 1'b0;
            o_nand_ce_n             <= 1'b1;
            block_protection_status <= 8'h00;
            nand_status             <= 8'h00;
            attempts                <= 5'h00;
            groups_tried            <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (ctrl_wr) begin
                        // a new write clears done and loads refused from the refusal check
                        refused <= refuse_now;
                        done    <= 1'b0;
                        if (!refuse_now) begin
                            op          <= i_pwdata[2:0];
                            idx         <= 5'h00;
                            o_nand_ce_n <= 1'b0;
                            state       <= S_ISSUE;
                            if (i_pwdata[2:0] == `NBP_OP_PERMANENT) begin
                                // every sequence counts as an attempt
                                attempts <= attempts + 5'h01;
                                groups_tried[perm_reg[`NBP_PERM_GROUP]] <= 1'b1;
                            end
                        end
                    end
                end
                S_ISSUE: begin
                    cyc_start <= 1'b1;
                    state     <= S_WAIT;
                end
                S_WAIT: begin
                    if (ctrl_wr)
                        refused <= 1'b1; // busy: order dropped
                    if (cyc_done) begin
                        if (step[9:8] == `NBP_K_READ) begin
                            if (op == `NBP_OP_STATUS)
                                block_protection_status <= cyc_rdata;
                            else
                                nand_status <= cyc_rdata;
                        end
                        if (step[10]) begin
                            done        <= 1'b1;
                            o_nand_ce_n <= 1'b1;
                            state       <= S_IDLE;
                        end else begin
                            idx   <= idx + 5'h01;
                            state <= S_ISSUE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // byte-bus cycle engine
    nbp_cycle u_cycle (
        .i_clk             (i_clk),
        .i_srst            (i_srst),
        .i_start           (cyc_start),
        .i_kind            (step[9:8]),
        .i_byte            (step[7:0]),
        .i_nand_io         (i_nand_io),
        .i_ready_busy_line (i_ready_busy_line),
        .o_done            (cyc_done),
        .o_rdata           (cyc_rdata),
        .o_nand_cle        (o_nand_cle),
        .o_nand_ale        (o_nand_ale),
        .o_nand_we_n       (o_nand_we_n),
        .o_nand_re_n       (o_nand_re_n),
        .o_nand_io         (o_nand_io),
        .o_nand_io_oe      (o_nand_io_oe)
    );
endmodule // nbp_host

// File: tb/nbp_host_properties.sv
`timescale 1ns/10ps
// pin-level checks of the host side of the byte bus
module nbp_host_properties (
    input wire logic       i_clk, i_srst, i_ready_busy_line,
    input wire logic [7:0] o_nand_io,
    input wire logic       o_nand_cle, o_nand_ale, o_nand_ce_n, o_nand_we_n, o_nand_re_n,
    input wire logic       o_write_protect_n, o_volatile_protect_enable_pin
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // command byte under a write strobe
    wire cw = o_nand_cle & ~o_nand_we_n;
    wire vc = cw & (o_nand_io == 8'h23 | o_nand_io == 8'h24 | o_nand_io == 8'h2a);
    a_lockdown_pins: assert property (cw && o_nand_io == 8'h2c |-> o_write_protect_n
        && o_volatile_protect_enable_pin) else $error("lock-down with a pin low");
    a_volatile_enable: assert property (vc |-> o_volatile_protect_enable_pin)
        else $error("volatile command with enable low");
    a_reset_ready: assert property (cw && o_nand_io == 8'hff |-> i_ready_busy_line)
        else $error("reset sent while busy");
    a_we_pulse: assert property ($fell(o_nand_we_n) |=> o_nand_we_n)
        else $error("write strobe not one cycle");
    a_read_pulse: assert property ($fell(o_nand_re_n) |=> !o_nand_re_n ##1 o_nand_re_n)
        else $error("read strobe not two cycles");
    a_ce_framed: assert property (!(o_nand_we_n && o_nand_re_n) |-> !o_nand_ce_n)
        else $error("strobe without chip enable");
    a_latch_excl: assert property (!(o_nand_cle && o_nand_ale))
        else $error("both latch enables high");
    a_cmd_setup: assert property ($rose(o_nand_cle) |-> o_nand_we_n ##1 !o_nand_we_n)
        else $error("command setup cycle missing");
    c_lockdown: cover property (cw && o_nand_io == 8'h2c);
    c_group: cover property (cw && o_nand_io == 8'h41);
    c_status: cover property (cw && o_nand_io == 8'h7a);
endmodule // nbp_host_properties
bind nbp_host nbp_host_properties u_nbp_host_properties (.i_clk, .i_srst, .i_ready_busy_line,
    .o_nand_io, .o_nand_cle, .o_nand_ale, .o_nand_ce_n, .o_nand_we_n, .o_nand_re_n,
    .o_write_protect_n, .o_volatile_protect_enable_pin);

// File: tb/nbp_nand_model.sv
`timescale 1ns/10ps
// behavioural flash device: protection state, status byte, busy line
module nbp_nand_model (
    input  wire logic       i_clk, i_por, i_cle, i_ale, i_ce_n, i_we_n, i_re_n, i_wp_n, i_vpe,
    input  wire logic [7:0] i_io,
    output wire logic [7:0] o_io,
    output wire logic       o_rb
);
    logic [23:0] ad = 0;
    logic [10:0] lb = 0, ub = 0, blk = 0;
    logic [15:0] pg = 0;
    logic [7:0]  cmd = 0;
    logic [4:0]  bc = 0;
    logic [2:0]  n = 0;
    logic        en = 0, rv = 0, inv = 0, ld = 0, pl = 0, pw = 1, pm = 0, pf = 0;
    wire  [10:0] ba = {i_io[0], ad[23:16], ad[15:14]};
    wire         inr = blk >= lb && blk <= ub;
    wire         vp = en && !(rv && (inv ? !inr : inr));
    // status byte; a released bus shows its inverse
    wire  [7:0]  sb = {3'h0, pl, !(blk < 64 && pg[blk[5:2]]), !vp, !ld, ld};
    // status after 70h: bit 0 set when the last program was refused
    wire  [7:0]  ob = cmd == 8'h70 ? {i_wp_n, 1'b1, 5'h0, pf} : sb;
    assign o_io = i_re_n ? ~ob : ob;
    assign o_rb = bc == 0;
    // a bus cycle is taken as the write strobe rises
    always @(posedge i_clk) begin
        pw <= i_we_n;
        if (bc != 0) bc <= bc - 1;
        if (i_we_n && !pw && !i_ce_n && i_cle) begin
            cmd <= i_io;
            n <= 0;
            if (i_io == 8'h2a && i_vpe && !ld) rv <= 0;
            if (i_io == 8'h2c && i_vpe && !ld) ld <= 1;
            // group program from the fourth byte
            pm <= (pm || i_io == 8'h41) && i_io != 8'hff;
            if (i_io == 8'h10 && pm) begin
                bc <= 20;
                pf <= pl; // frozen groups refuse the program
                pl <= pl | ad[12];
                if (!pl) pg[ad[11:8]] <= 1;
            end
            if (i_io == 8'hff) bc <= 4;
        end
        if (i_we_n && !pw && !i_ce_n && i_ale) begin
            ad <= {i_io, ad[23:8]};
            n <= n + 1;
            // block address, invert only from 24h
            if (n == 2) blk <= ba;
            if (n == 2 && cmd == 8'h23 && i_vpe && !ld) lb <= ba;
            if (n == 2 && cmd == 8'h24 && i_vpe && !ld) begin
                ub <= ba;
                inv <= ad[8];
                rv <= 1;
            end
        end
        // write-protect low drops the range before lock-down
        if (!i_wp_n && !ld) rv <= 0;
        if (i_por) begin
            en <= i_vpe;
            ld <= 0;
            rv <= 0;
        end
    end
endmodule // nbp_nand_model

// File: tb/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
// apb tasks drive the host, the model plays the device
module testbench;
    logic        i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, por = 1, er;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic [7:0]  i_nand_io, o_nand_io, dio;
    logic        o_pready, o_pslverr, o_nand_io_oe, o_nand_cle, o_nand_ale, o_nand_ce_n;
    logic        o_nand_we_n, o_nand_re_n, o_write_protect_n, o_volatile_protect_enable_pin;
    logic        i_ready_busy_line;
    int          errors = 0, check_count = 0, cyc = 0;
    always #12.5 i_clk = ~i_clk;
    assign i_nand_io = o_nand_io_oe ? o_nand_io : dio; // resolved byte bus
    nbp_host u_nbp_host (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_nand_io, .i_ready_busy_line, .o_nand_io,
        .o_nand_io_oe, .o_nand_cle, .o_nand_ale, .o_nand_ce_n, .o_nand_we_n, .o_nand_re_n,
        .o_write_protect_n, .o_volatile_protect_enable_pin);
    nbp_nand_model u_nbp_nand_model (.i_clk, .i_por(por), .i_cle(o_nand_cle),
        .i_ale(o_nand_ale), .i_ce_n(o_nand_ce_n), .i_we_n(o_nand_we_n), .i_re_n(o_nand_re_n),
        .i_wp_n(o_write_protect_n), .i_vpe(o_volatile_protect_enable_pin), .i_io(i_nand_io),
        .o_io(dio), .o_rb(i_ready_busy_line));
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic op(input logic [2:0] o);
        int k;
        apb(1, 12'h000, {29'h0, o});
        k = 0;
        do begin
            apb(0, 12'h010, 0);
            k++;
        end while (rd[2:1] == 2'b00 && k < 200);
        `CHK(rd[2:1] != 2'b00, 1'b1)
    endtask
    task automatic st(input logic [10:0] b, input logic [7:0] e);
        apb(1, 12'h004, {21'h0, b});
        op(5);
        `CHK(rd[15:8], e)
    endtask
    task automatic un(input logic [10:0] l, input logic [10:0] u, input logic v);
        apb(1, 12'h004, {v, 4'h0, u, 5'h0, l});
        op(1);
    endtask
    task automatic pm(input logic [4:0] g);
        apb(1, 12'h008, {27'h0, g});
        op(4);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_srst <= 0;
        apb(0, 12'h014, 0);
        `CHK(rd, 32'h0)
        apb(0, 12'h020, 0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1, 12'h00c, 3);
        repeat (2) @(posedge i_clk);
        por <= 0;
        op(6);
        `CHK(rd[2], 1'b1)
        op(0);
        `CHK(rd[3:1], 3'b101)
        $display("reset test done");
        st(5, 8'h0a);
        un(4, 9, 0);
        st(4, 8'h0e);
        st(10, 8'h0a);
        un(4, 9, 1);
        st(4, 8'h0a);
        st(3, 8'h0e);
        op(2);
        st(3, 8'h0a);
        $display("range test done");
        un(0, 7, 0);
        apb(1, 12'h00c, 2);
        st(0, 8'h0a);
        op(3);
        `CHK(rd[2], 1'b1)
        apb(1, 12'h00c, 3);
        un(0, 7, 0);
        op(3);
        apb(1, 12'h00c, 2);
        op(2);
        st(0, 8'h0d);
        st(8, 8'h09);
        $display("lock-down test done");
        apb(1, 12'h00c, 3);
        pm(2);
        `CHK(rd[23:16], 8'hc0)
        st(8, 8'h01);
        pm(5'h10);
        st(0, 8'h15);
        pm(5);
        `CHK(rd[23:16], 8'hc1)
        st(20, 8'h19);
        pm(2);
        `CHK({rd[28:24], rd[2]}, 6'h07)
        $display("permanent test done");
        test_done;
    end
endmodule // testbench
